// ### hdl/dcu_pkg.sv
package dcu_pkg;
  localparam int NUM_CH = 8;
  localparam int CODE_W = 12;
  localparam int FRAME_BITS = 32;
  // frame field positions
  localparam int CMD_MSB = 27;
  localparam int CMD_LSB = 24;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 20;
  localparam int DATA_MSB = 19;
  localparam int DATA_LSB = 8;
  localparam int PD_MSB = 9;
  localparam int PD_LSB = 8;
  // command codes
  localparam logic [3:0] CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] CMD_UPDATE_N = 4'h1;
  localparam logic [3:0] CMD_WRITE_ALL = 4'h2;
  localparam logic [3:0] CMD_SW_LOAD = 4'h3;
  localparam logic [3:0] CMD_POWERDOWN = 4'h4;
  localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
  localparam logic [3:0] CMD_LOAD_MASK = 4'h6;
  localparam logic [3:0] ADDR_ALL = 4'hF;
  // clear codes
  localparam logic [1:0] CLR_ZERO = 2'h0;
  localparam logic [1:0] CLR_MID = 2'h1;
  localparam logic [1:0] CLR_FULL = 2'h2;
  localparam logic [1:0] CLR_NOP = 2'h3;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  // power-down modes
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_TRI = 2'h3;
  // reset values
  localparam logic [1:0] CLR_SEL_RST = 2'h0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [5:0] CNT_RST = 6'h00;
endpackage

// ### hdl/dcu_top.sv
`timescale 1ns/10ps
// What this block does
// - a power-down frame has command 0100, mode in bits 9:8 and a channel select mask in bits 7:0.
// - the clear-code setting picks zero scale, midscale, full scale, or no clear for 11.
// - a clear-code frame has command 0101 with the new setting in bits 1:0.
// - with the strobe low, a channel's DAC register updates at the end of the 32-bit frame.
// - otherwise command 0000 touches input registers only and a strobe fall copies them to DAC registers of channels with override bit 0.
// - command 0011 writes the addressed input register then updates every DAC register.
// - a channel with override bit 1 updates as though the strobe were held low.
// - command 0110 loads the eight-bit override mask from bits 7:0, reset to zero.
// - power-down, clear-code and mask commands ignore the address and unused bits.
// - power-down mode 00 is normal, 01 is 1k to ground, 10 is 100k, 11 is three-state.
// - frame sync rising before the 32nd falling clock edge discards the frame.
// - a clear pin fall loads all input and DAC registers with the clear code (none for setting 11) and aborts a frame.
module dcu_top #(
  parameter int NUM_CH = dcu_pkg::NUM_CH,
  parameter int CODE_W = dcu_pkg::CODE_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic dac_serial_clock,
  input wire logic dac_frame_sync,
  input wire logic dac_serial_data,
  input wire logic load_strobe,
  input wire logic clear_pin,
  output logic [NUM_CH*CODE_W-1:0] dac_code,
  output logic [NUM_CH*CODE_W-1:0] input_code,
  output logic [NUM_CH*2-1:0] powerdown_mode,
  output logic [1:0] clear_code_select,
  output logic [NUM_CH-1:0] load_override_mask
);

  // link domain: shift on falling serial clock while sync low
  logic [31:0] sh_q, sh_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] word_q, word_d;
  logic tog_q, tog_d;
  logic abort_l1_q, abort_l1_d;
  logic abort_l2_q, abort_l2_d;
  logic link_busy;
  // core-side abort request, read by the link synchroniser below
  logic abort_q, abort_d;

  // shifting stops once the frame is complete or a clear has aborted it
  assign link_busy = !abort_l2_q && cnt_q != 6'(dcu_pkg::FRAME_BITS);

  always_comb begin
    sh_d = sh_q;
    cnt_d = cnt_q;
    word_d = word_q;
    tog_d = tog_q;
    if (link_busy) begin
      sh_d = {sh_q[30:0], dac_serial_data};
      cnt_d = cnt_q + 6'h01;
      // last bit completes the word and flips the toggle
      if (cnt_q == 6'(dcu_pkg::FRAME_BITS - 1)) begin
        word_d = {sh_q[30:0], dac_serial_data};
        tog_d = ~tog_q;
      end
    end
  end

  // sync high resets the shifter, so a short frame never completes
  always_ff @(negedge dac_serial_clock or posedge dac_frame_sync) begin
    if (dac_frame_sync) begin
      cnt_q <= dcu_pkg::CNT_RST;
      sh_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  // word stays put until the next whole frame, so the core may read it after the toggle
  always_ff @(negedge dac_serial_clock or negedge rstn) begin
    if (!rstn) begin
      word_q <= 32'h0000_0000;
      tog_q <= 1'b0;
    end else begin
      word_q <= word_d;
      tog_q <= tog_d;
    end
  end

  // abort reaches the link after two serial clock falls
  always_comb begin
    abort_l1_d = abort_q;
    abort_l2_d = abort_l1_q;
  end

  // sync high clears the abort too; the serial clock stands still between
  // frames, so a stale abort would otherwise eat the next frame's first bits
  always_ff @(negedge dac_serial_clock or negedge rstn or posedge dac_frame_sync) begin
    if (!rstn || dac_frame_sync) begin
      abort_l1_q <= 1'b0;
      abort_l2_q <= 1'b0;
    end else begin
      abort_l1_q <= abort_l1_d;
      abort_l2_q <= abort_l2_d;
    end
  end

  // core domain: synchronisers, two flops before any logic, a third for edges
  logic [2:0] tog_s_q, tog_s_d;
  logic [2:0] ld_s_q, ld_s_d;
  logic [2:0] clr_s_q, clr_s_d;
  logic [1:0] fs_s_q, fs_s_d;

  always_comb begin
    tog_s_d = {tog_s_q[1:0], tog_q};
    ld_s_d = {ld_s_q[1:0], load_strobe};
    clr_s_d = {clr_s_q[1:0], clear_pin};
    fs_s_d = {fs_s_q[0], dac_frame_sync};
  end

  // pins reset to their idle high level, so no false edge follows reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tog_s_q <= 3'h0;
      ld_s_q <= 3'h7;
      clr_s_q <= 3'h7;
      fs_s_q <= 2'h3;
    end else if (clk_en) begin
      tog_s_q <= tog_s_d;
      ld_s_q <= ld_s_d;
      clr_s_q <= clr_s_d;
      fs_s_q <= fs_s_d;
    end
  end

  logic frame_ev, strobe_fall, strobe_low, clr_fall;
  // a toggle change marks one complete word from the link
  assign frame_ev = tog_s_q[2] ^ tog_s_q[1];
  assign strobe_fall = ld_s_q[2] & ~ld_s_q[1];
  // the strobe level is taken when the frame arrives in this domain
  assign strobe_low = ~ld_s_q[1];
  assign clr_fall = clr_s_q[2] & ~clr_s_q[1];

  function automatic logic [11:0] clear_value(input logic [1:0] sel);
    unique case (sel)
      dcu_pkg::CLR_ZERO: clear_value = dcu_pkg::CODE_ZERO;
      dcu_pkg::CLR_MID: clear_value = dcu_pkg::CODE_MID;
      dcu_pkg::CLR_FULL: clear_value = dcu_pkg::CODE_FULL;
      // no clear is gated by the caller, so the value here is never used
      dcu_pkg::CLR_NOP: clear_value = dcu_pkg::CODE_ZERO;
    endcase
  endfunction

  // word is stable after its toggle, synchronised, so it may be sampled here
  logic [3:0] cmd, addr;
  logic [11:0] data;
  assign cmd = word_q[dcu_pkg::CMD_MSB:dcu_pkg::CMD_LSB];
  assign addr = word_q[dcu_pkg::ADDR_MSB:dcu_pkg::ADDR_LSB];
  assign data = word_q[dcu_pkg::DATA_MSB:dcu_pkg::DATA_LSB];

  // commands that write or update code registers
  function automatic logic is_data_cmd(input logic [3:0] c);
    unique case (c)
      dcu_pkg::CMD_WRITE_IN, dcu_pkg::CMD_UPDATE_N: is_data_cmd = 1'b1;
      dcu_pkg::CMD_WRITE_ALL, dcu_pkg::CMD_SW_LOAD: is_data_cmd = 1'b1;
      default: is_data_cmd = 1'b0;
    endcase
  endfunction

  // address 15 selects every channel
  function automatic logic addr_hits(input logic [3:0] a, input int ch);
    addr_hits = a == 4'(ch) || a == dcu_pkg::ADDR_ALL;
  endfunction

  logic [NUM_CH*CODE_W-1:0] in_q, in_d, dac_q, dac_d;
  logic [NUM_CH*2-1:0] pd_q, pd_d;
  logic [1:0] csel_q, csel_d;
  logic [NUM_CH-1:0] mask_q, mask_d;
  logic [NUM_CH-1:0] hit;
  logic take;

  // a frame is dropped while a clear abort is still held
  assign take = frame_ev && !abort_q;

  // per-channel address match
  for (genvar g = 0; g < NUM_CH; g++) begin : g_hit
    assign hit[g] = addr_hits(addr, g);
  end

  // abort held until the sync goes high, so the next frame starts clean
  always_comb begin
    abort_d = abort_q & ~fs_s_q[1];
    // a clear fall sets the abort; the set wins over the release
    if (clr_fall) begin
      abort_d = 1'b1;
    end
  end

  // a clear while no frame runs is released at once, since sync is high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      abort_q <= 1'b0;
    end else if (clk_en) begin
      abort_q <= abort_d;
    end
  end

  // settings group: power-down modes, clear code and override mask
  always_comb begin
    pd_d = pd_q;
    csel_d = csel_q;
    mask_d = mask_q;
    if (take) begin
      unique case (cmd)
        dcu_pkg::CMD_POWERDOWN: begin
          // mode per selected channel; address ignored
          for (int i = 0; i < NUM_CH; i++) begin
            if (word_q[i]) begin
              pd_d[i*2 +: 2] = word_q[dcu_pkg::PD_MSB:dcu_pkg::PD_LSB];
            end
          end
        end
        dcu_pkg::CMD_CLEAR_CODE: csel_d = word_q[1:0];
        dcu_pkg::CMD_LOAD_MASK: mask_d = word_q[NUM_CH-1:0];
        // data commands and unused codes leave the settings alone
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pd_q <= '0;
      csel_q <= dcu_pkg::CLR_SEL_RST;
      mask_q <= dcu_pkg::MASK_RST;
    end else if (clk_en) begin
      pd_q <= pd_d;
      csel_q <= csel_d;
      mask_q <= mask_d;
    end
  end

  // code group: input and DAC registers
  always_comb begin
    in_d = in_q;
    dac_d = dac_q;
    if (take && is_data_cmd(cmd)) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit[i]) begin
          if (cmd != dcu_pkg::CMD_UPDATE_N) begin
            in_d[i*CODE_W +: CODE_W] = data;
          end
          if (strobe_low || mask_q[i] || cmd != dcu_pkg::CMD_WRITE_IN) begin
            dac_d[i*CODE_W +: CODE_W] = in_d[i*CODE_W +: CODE_W];
          end
        end
      end
      if (cmd == dcu_pkg::CMD_SW_LOAD) begin
        dac_d = in_d;
      end
    end
    // strobe fall copies input to DAC registers of channels whose override bit is 0
    if (strobe_fall) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!mask_q[i]) begin
          dac_d[i*CODE_W +: CODE_W] = in_d[i*CODE_W +: CODE_W];
        end
      end
    end
    // clear pin fall wins over everything; code 11 leaves all alone
    if (clr_fall && csel_q != dcu_pkg::CLR_NOP) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_d[i*CODE_W +: CODE_W] = clear_value(csel_q);
        dac_d[i*CODE_W +: CODE_W] = clear_value(csel_q);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_q <= '0;
      dac_q <= '0;
    end else if (clk_en) begin
      in_q <= in_d;
      dac_q <= dac_d;
    end
  end

  // outputs come straight from the registers

  assign dac_code = dac_q;
  assign input_code = in_q;
  assign powerdown_mode = pd_q;
  assign clear_code_select = csel_q;
  assign load_override_mask = mask_q;

endmodule // dcu_top

// ### testbench/dcu_host_model.sv
`timescale 1ns/10ps
module dcu_host_model (
  output logic dac_serial_clock,
  output logic dac_frame_sync,
  output logic dac_serial_data
);
  // link clock stands still high between frames
  initial begin
    dac_serial_clock = 1'b1;
    dac_frame_sync = 1'b1;
    dac_serial_data = 1'b0;
  end
  task automatic send(input logic [31:0] w, input int nbits);
    #23.0 dac_frame_sync = 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      dac_serial_data = w[i];
      #62.5 dac_serial_clock = 1'b0;
      #62.5 dac_serial_clock = 1'b1;
    end
    #40.0 dac_frame_sync = 1'b1;
    // released line must not keep the last bit
    dac_serial_data = ~dac_serial_data;
  endtask
endmodule // dcu_host_model

// ### testbench/dcu_top_assertions.sv
`timescale 1ns/10ps
module dcu_top_assertions #(
  parameter int NUM_CH = 8,
  parameter int CODE_W = 12
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dac_frame_sync,
  input wire logic load_strobe,
  input wire logic clear_pin,
  input wire logic [NUM_CH*CODE_W-1:0] dac_code,
  input wire logic [NUM_CH*CODE_W-1:0] input_code,
  input wire logic [NUM_CH*2-1:0] powerdown_mode,
  input wire logic [1:0] clear_code_select,
  input wire logic [NUM_CH-1:0] load_override_mask
);
  logic [3:0] quiet_q, quiet_d;
  // idle count, so late updates of the last frame are not flagged
  always_comb quiet_d = (!dac_frame_sync || !load_strobe || !clear_pin) ? 4'h0 :
      quiet_q + {3'h0, quiet_q != 4'hF};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) quiet_q <= 4'h0;
    else quiet_q <= quiet_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_rst_zero: assert property ($rose(rstn) |-> dac_code == '0 && load_override_mask == '0)
    else $error("outputs not zero after reset");
  chk_clr_zero: assert property ($fell(clear_pin) && clear_code_select == 2'h0 |->
    ##[1:6] dac_code == '0 && input_code == '0) else $error("clear to zero missed");
  chk_clr_mid: assert property ($fell(clear_pin) && clear_code_select == 2'h1 |->
    ##[1:6] dac_code == {NUM_CH{12'h800}}) else $error("clear to mid missed");
  chk_clr_full: assert property ($fell(clear_pin) && clear_code_select == 2'h2 |->
    ##[1:6] input_code == {NUM_CH{12'hFFF}}) else $error("clear to full missed");
  chk_clr_nop: assert property ($fell(clear_pin) && clear_code_select == 2'h3 |=>
    $stable(dac_code) [*4]) else $error("clear code 11 changed outputs");
  chk_strobe_copy: assert property ($fell(load_strobe) && clear_pin |->
    ##[1:6] dac_code == input_code) else $error("strobe did not copy");
  chk_idle_data: assert property (quiet_q > 4'h7 |-> $stable(dac_code) && $stable(input_code))
    else $error("codes moved while idle");
  chk_idle_cfg: assert property (quiet_q > 4'h7 |-> $stable(powerdown_mode) &&
    $stable(clear_code_select) && $stable(load_override_mask)) else $error("setting moved");
endmodule // dcu_top_assertions
bind dcu_top dcu_top_assertions #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) dcu_top_assertions_inst (
  .ref_clk(ref_clk), .rstn(rstn), .dac_frame_sync(dac_frame_sync), .load_strobe(load_strobe),
  .clear_pin(clear_pin), .dac_code(dac_code), .input_code(input_code),
  .powerdown_mode(powerdown_mode), .clear_code_select(clear_code_select),
  .load_override_mask(load_override_mask));

// ### testbench/dcu_top_tb.sv
`timescale 1ns/10ps
module dcu_top_tb;
  logic ref_clk = 1'b0, rstn = 1'b0, load_strobe = 1'b1, clear_pin = 1'b1;
  logic sclk, fsync, sdat;
  logic [95:0] dac_code, input_code, e_dac = '0, e_in = '0;
  logic [15:0] powerdown_mode, e_pd = '0;
  logic [1:0] clear_code_select, e_sel = '0;
  logic [7:0] load_override_mask, e_mask = '0;
  logic [217:0] q[$];
  logic [217:0] exp_v;
  int n_fail = 0, checked = 0;
  event chk_ev;
  wire logic [217:0] got = {dac_code, input_code, powerdown_mode, clear_code_select,
    load_override_mask};
  always #25 ref_clk = ~ref_clk;
  dcu_host_model dcu_host_model_inst (.dac_serial_clock(sclk), .dac_frame_sync(fsync),
    .dac_serial_data(sdat));
  dcu_top dcu_top_inst (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1), .dac_serial_clock(sclk),
    .dac_frame_sync(fsync), .dac_serial_data(sdat), .load_strobe(load_strobe),
    .clear_pin(clear_pin), .dac_code(dac_code), .input_code(input_code),
    .powerdown_mode(powerdown_mode), .clear_code_select(clear_code_select),
    .load_override_mask(load_override_mask));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic note();
    @(negedge ref_clk);
    q.push_back({e_dac, e_in, e_pd, e_sel, e_mask});
    -> chk_ev;
  endtask
  function automatic void apply(input logic [31:0] f);
    for (int c = 0; c < 8; c++) begin
      if (f[27:24] <= 4'h3 && (f[23:20] == c || f[23:20] == 4'hF)) begin
        if (f[27:24] != 4'h1) e_in[c*12 +: 12] = f[19:8];
        if (!load_strobe || e_mask[c] || f[27:24] != 4'h0)
          e_dac[c*12 +: 12] = e_in[c*12 +: 12];
      end
      if (f[27:24] == 4'h4 && f[c]) e_pd[c*2 +: 2] = f[9:8];
    end
    if (f[27:24] == 4'h3) e_dac = e_in;
    if (f[27:24] == 4'h5) e_sel = f[1:0];
    if (f[27:24] == 4'h6) e_mask = f[7:0];
  endfunction
  task automatic frame(input logic [31:0] f, input int nb);
    dcu_host_model_inst.send(f, nb);
    if (nb == 32) apply(f);
    cyc(8);
    note();
  endtask
  task automatic clear_pulse();
    cyc(1);
    clear_pin <= 1'b0;
    cyc(3);
    clear_pin <= 1'b1;
    if (e_sel != 2'h3) e_in = {8{e_sel == 2'h0 ? 12'h000 : e_sel == 2'h1 ? 12'h800 : 12'hFFF}};
    if (e_sel != 2'h3) e_dac = e_in;
    cyc(8);
    note();
  endtask
  task automatic finish_test();
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(chk_ev) begin
    exp_v = q.pop_front();
    checked++;
    if (exp_v !== got) begin
      n_fail++;
      $display("[ERR] %0t exp %h got %h", $time, exp_v, got);
    end
  end
  initial begin
    cyc(20000);
    n_fail++;
    finish_test();
  end
  initial begin
    void'($urandom(46025));
    cyc(2);
    rstn <= 1'b1;
    cyc(2);
    note();
    for (int m = 0; m < 4; m++) frame({4'($urandom), 4'h4, 14'($urandom), m[1:0], 8'($urandom)}, 32);
    for (int c = 0; c < 4; c++) begin
      frame({4'($urandom), 4'h5, 22'($urandom), c[1:0]}, 32);
      frame({8'h00, 4'($urandom & 7), 12'($urandom), 8'h00}, 32);
      clear_pulse();
    end
    cyc(1);
    load_strobe <= 1'b0;
    e_dac = e_in;
    cyc(4);
    note();
    frame({8'h00, 4'hF, 12'($urandom), 8'h00}, 32);
    cyc(1);
    load_strobe <= 1'b1;
    frame({4'($urandom), 4'h6, 16'($urandom), 8'h5A}, 32);
    frame({8'h00, 4'hF, 12'($urandom), 8'h00}, 32);
    frame({8'h01, 4'($urandom & 7), 20'h00000}, 32);
    frame({8'h02, 4'($urandom & 7), 12'($urandom), 8'h00}, 32);
    frame({8'h03, 4'h2, 12'($urandom), 8'h00}, 32);
    frame({8'h06, 16'h0000, 8'hFF}, 20);
    frame({8'h05, 22'h0, 2'h1}, 32);
    fork
      dcu_host_model_inst.send({8'h00, 4'h1, 12'hABC, 8'h00}, 32);
      clear_pulse();
    join
    cyc(8);
    note();
    frame({8'h06, 24'h000000}, 32);
    finish_test();
  end
endmodule // dcu_top_tb
